/* hw/qct_pkg.sv */
package qct_pkg;

  // Counter geometry and reset values
  localparam int QCT_CNT_W = 16;
  localparam logic [15:0] QCT_CNT_RST = 16'h0000;
  localparam logic [15:0] QCT_GRA_RST = 16'hffff;
  localparam logic [15:0] QCT_MIDSCALE = 16'h8000;

  // Prescaler: widest division is 64, so six bits
  localparam int QCT_PRESC_W = 6;
  localparam logic [5:0] QCT_PRESC_RST = 6'h00;

  // Clock period; one count per system clock gives this resolution
  localparam int QCT_CLK_PERIOD_NS = 5;
  localparam int QCT_STEP_NS = QCT_CLK_PERIOD_NS * 1;

  // Counter clock source
  typedef enum logic [1:0] {
    QCT_CLK_DIV1 = 2'b00,
    QCT_CLK_DIV4 = 2'b01,
    QCT_CLK_DIV16 = 2'b10,
    QCT_CLK_DIV64 = 2'b11
  } qct_clk_sel_t;

  // Counter clear source
  typedef enum logic [1:0] {
    QCT_CLR_NONE = 2'b00,
    QCT_CLR_CH0_GRA = 2'b01,
    QCT_CLR_RSVD2 = 2'b10,
    QCT_CLR_RSVD3 = 2'b11
  } qct_clr_sel_t;

  // Channel 0 GRA function
  typedef enum logic [1:0] {
    QCT_IO0_COMPARE = 2'b00,
    QCT_IO0_CAP_RISE = 2'b01,
    QCT_IO0_CAP_FALL = 2'b10,
    QCT_IO0_CAP_BOTH = 2'b11
  } qct_io0_t;

  // Channel 1 counting mode
  typedef enum logic {
    QCT_MODE_NORMAL = 1'b0,
    QCT_MODE_PHASE1 = 1'b1
  } qct_mode_t;

  typedef struct packed {
    qct_clk_sel_t clk_sel;
    qct_clr_sel_t clr_sel;
  } qct_ctrl_t;

  typedef struct packed {
    logic gfa_en;
    logic unf_en;
    logic ovf_en;
  } qct_irq_en_t;

  typedef struct packed {
    logic gfa;
    logic unf;
    logic ovf;
  } qct_status_t;

  localparam qct_ctrl_t QCT_CTRL_RST = '{clk_sel: QCT_CLK_DIV1, clr_sel: QCT_CLR_NONE};

endpackage : qct_pkg

/* hw/qct_sticky_flag.sv */
`timescale 1ns/100ps
`default_nettype none
module qct_sticky_flag
  import qct_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Event and software access
  input wire logic set_evt,
  input wire logic sw_rd,
  input wire logic sw_wr,
  input wire logic sw_wval,
  // Flag state
  output logic flag
);

  logic flag_reg;
  logic flag_next;
  logic armed_reg;
  logic armed_next;
  wire clr_ok;

  ////////////////////////////////////////////////////////////////////////
  // read-one then zero
  assign clr_ok = sw_wr && !sw_wval && armed_reg;
  // Set beats a same-cycle clear so no event is lost
  assign flag_next = set_evt ? 1'b1 : (clr_ok ? 1'b0 : flag_reg);
  // Any write disarms; a read that sees one arms
  assign armed_next = sw_wr ? 1'b0 : ((sw_rd && flag_reg) ? 1'b1 : armed_reg);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flag_reg <= 1'b0;
      armed_reg <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
      armed_reg <= armed_next;
    end
  end

  assign flag = flag_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  flag_clear_rule_a: assert property (@(posedge clk) disable iff (rst)
    (flag_reg && !set_evt && sw_wr && !sw_wval && armed_reg) |=> !flag_reg)
    else $error("armed zero write did not clear flag");
  set_wins_a: assert property (@(posedge clk) disable iff (rst)
    set_evt |=> flag_reg)
    else $error("flag event lost");
  no_blind_clear_a: assert property (@(posedge clk) disable iff (rst)
    (flag_reg && !armed_reg && !sw_rd) |=> flag_reg)
    else $error("flag cleared without prior read");

endmodule : qct_sticky_flag
`default_nettype wire

/* hw/qct_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module qct_timer
  import qct_pkg::*;
#(
  parameter int CNT_W = QCT_CNT_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Unit and channel run control
  input wire logic module_stop_control,
  input wire logic [1:0] counter_start_reg,
  // Channel configuration
  input wire qct_ctrl_t ch0_control_reg,
  input wire qct_ctrl_t ch1_control_reg,
  input wire qct_io0_t ch0_io_control,
  input wire logic ch1_io_control,
  input wire qct_mode_t ch1_mode_reg,
  input wire qct_irq_en_t ch0_irq_enable,
  input wire qct_irq_en_t ch1_irq_enable,
  // Software writes and status reads
  input wire logic ch0_cnt_wr,
  input wire logic ch1_cnt_wr,
  input wire logic ch0_gra_wr,
  input wire logic [CNT_W-1:0] sw_wdata,
  input wire logic ch0_status_rd,
  input wire logic ch1_status_rd,
  input wire logic ch0_status_wr,
  input wire logic ch1_status_wr,
  input wire qct_status_t status_wdata,
  // Pins
  input wire logic enc_phase_a_in,
  input wire logic enc_phase_b_in,
  input wire logic ch0_pin_a,
  // State seen by software
  output logic [CNT_W-1:0] ch0_counter,
  output logic [CNT_W-1:0] ch1_counter,
  output logic [CNT_W-1:0] ch0_general_reg_a,
  output logic [CNT_W-1:0] ch1_general_reg_a,
  output qct_status_t ch0_status,
  output qct_status_t ch1_status,
  // Interrupt requests
  output logic ch0_match_a_irq,
  output logic ch0_ovf_irq,
  output logic ch1_match_a_irq,
  output logic ch1_ovf_irq,
  output logic ch1_unf_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter check
  // Reset constants are sixteen bits wide, so wider counters cannot be served
  if (CNT_W < 8 || CNT_W > 16)
  begin : g_bad_width
    $error("qct_timer: CNT_W must be 8 to 16");
  end

  localparam logic [CNT_W-1:0] ONES = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  logic [QCT_PRESC_W-1:0] presc_reg;
  logic [CNT_W-1:0] cnt0_reg;
  logic [CNT_W-1:0] cnt1_reg;
  logic [CNT_W-1:0] gra0_reg;
  logic [CNT_W-1:0] gra1_reg;
  logic enc_a_reg;
  logic enc_b_reg;
  logic pin_reg;
  logic irq0_gfa_reg;
  logic irq0_ovf_reg;
  logic irq1_gfa_reg;
  logic irq1_ovf_reg;
  logic irq1_unf_reg;
  qct_status_t st0;
  qct_status_t st1;
  logic f0_gfa;
  logic f0_ovf;
  logic f1_gfa;
  logic f1_ovf;
  logic f1_unf;
  logic [CNT_W-1:0] cnt0_next;
  logic [CNT_W-1:0] cnt1_next;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler taps, one-cycle enables
  wire active = !module_stop_control;
  wire tick_d4 = (presc_reg[1:0] == 2'h3);
  wire tick_d16 = (presc_reg[3:0] == 4'hf);
  wire tick_d64 = (presc_reg == 6'h3f);

  function automatic logic pick_tick(input qct_clk_sel_t sel, input logic t4,
                                     input logic t16, input logic t64);
    logic t;
    unique case (sel)
      QCT_CLK_DIV1: t = 1'b1;
      QCT_CLK_DIV4: t = t4;
      QCT_CLK_DIV16: t = t16;
      QCT_CLK_DIV64: t = t64;
    endcase
    return t;
  endfunction : pick_tick

  // start bits gate counting; stop holds all
  wire run0 = active && counter_start_reg[0];
  wire run1 = active && counter_start_reg[1];
  // DIV1 advances once per system clock
  wire tick0 = run0 && pick_tick(ch0_control_reg.clk_sel, tick_d4, tick_d16, tick_d64);

  ////////////////////////////////////////////////////////////////////////
  // Channel 0 compare match and input capture
  wire ch0_is_cmp = (ch0_io_control == QCT_IO0_COMPARE);
  // match is internal only, no pin is driven
  wire ch0_match = active && ch0_is_cmp && tick0 && (cnt0_reg == gra0_reg);
  wire pin_rise = ch0_pin_a && !pin_reg;
  wire pin_fall = !ch0_pin_a && pin_reg;
  wire cap_edge = (ch0_io_control == QCT_IO0_CAP_RISE) ? pin_rise :
                  (ch0_io_control == QCT_IO0_CAP_FALL) ? pin_fall :
                  (ch0_io_control == QCT_IO0_CAP_BOTH) ? (pin_rise || pin_fall) : 1'b0;
  // capture only while the unit is awake
  wire ch0_cap = active && cap_edge;
  // Match or capture on GRA both count as the GRA event
  wire ch0_gra_evt = ch0_match || ch0_cap;
  // ch0 GRA as clear source; capture clears ch0 too, ch1 clears on ch0 match only
  wire clr0 = (ch0_control_reg.clr_sel == QCT_CLR_CH0_GRA) && ch0_gra_evt;
  wire clr1 = (ch1_control_reg.clr_sel == QCT_CLR_CH0_GRA) && ch0_match;
  wire ovf0 = tick0 && !clr0 && (cnt0_reg == ONES);

  ////////////////////////////////////////////////////////////////////////
  // Channel 1 phase decode
  wire phase_mode = (ch1_mode_reg == QCT_MODE_PHASE1);
  wire a_chg = enc_phase_a_in ^ enc_a_reg;
  wire b_chg = enc_phase_b_in ^ enc_b_reg;
  // B leading A counts up, A leading B counts down
  wire enc_up = (a_chg && (enc_phase_a_in ^ enc_phase_b_in) == 1'b1 ? 1'b0 : a_chg) ||
                (b_chg && (enc_phase_a_in ^ enc_phase_b_in));
  wire enc_dn = (a_chg && (enc_phase_a_in ^ enc_phase_b_in)) ||
                (b_chg && !(enc_phase_a_in ^ enc_phase_b_in));
  // Both pins moving at once has no defined direction and is dropped
  wire enc_ok = !(a_chg && b_chg);
  // phase mode uses encoder edges in place of the prescaler
  wire up1 = run1 && (phase_mode ? (enc_ok && enc_up) :
             pick_tick(ch1_control_reg.clk_sel, tick_d4, tick_d16, tick_d64));
  wire dn1 = run1 && phase_mode && enc_ok && enc_dn;
  wire ovf1 = up1 && !clr1 && (cnt1_reg == ONES);
  wire unf1 = dn1 && !clr1 && (cnt1_reg == '0);
  // ch1 captures on ch0 compare match
  wire cap1 = ch1_io_control && ch0_match;

  ////////////////////////////////////////////////////////////////////////
  // Counter next values: software write, then clear, then count
  always_comb
  begin
    cnt0_next = cnt0_reg;
    cnt1_next = cnt1_reg;
    if (active && ch0_cnt_wr)
      cnt0_next = sw_wdata;
    else if (clr0)
      cnt0_next = '0;
    else if (tick0)
      cnt0_next = cnt0_reg + ONE;
    if (active && ch1_cnt_wr)
      cnt1_next = sw_wdata;
    else if (clr1)
      cnt1_next = '0;
    else if (up1)
      cnt1_next = cnt1_reg + ONE;
    else if (dn1)
      cnt1_next = cnt1_reg - ONE;
  end

  // Counters, prescaler and pin history
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      presc_reg <= QCT_PRESC_RST;
      cnt0_reg <= QCT_CNT_RST[CNT_W-1:0];
      cnt1_reg <= QCT_CNT_RST[CNT_W-1:0];
      enc_a_reg <= 1'b0;
      enc_b_reg <= 1'b0;
      pin_reg <= 1'b0;
    end
    else
    begin
      presc_reg <= active ? presc_reg + 6'h01 : presc_reg;
      cnt0_reg <= cnt0_next;
      cnt1_reg <= cnt1_next;
      enc_a_reg <= enc_phase_a_in;
      enc_b_reg <= enc_phase_b_in;
      pin_reg <= ch0_pin_a;
    end
  end

  // General registers; a capture beats a software write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gra0_reg <= QCT_GRA_RST[CNT_W-1:0];
      gra1_reg <= QCT_GRA_RST[CNT_W-1:0];
    end
    else
    begin
      if (ch0_cap)
        gra0_reg <= cnt0_reg;
      else if (active && ch0_gra_wr)
        gra0_reg <= sw_wdata;
      if (cap1)
        gra1_reg <= cnt1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags
  // capture sets ch0 flag; events to status
  qct_sticky_flag u_f0_gfa (.clk(clk), .rst(rst), .set_evt(ch0_gra_evt),
    .sw_rd(ch0_status_rd), .sw_wr(ch0_status_wr), .sw_wval(status_wdata.gfa),
    .flag(f0_gfa));
  qct_sticky_flag u_f0_ovf (.clk(clk), .rst(rst), .set_evt(ovf0),
    .sw_rd(ch0_status_rd), .sw_wr(ch0_status_wr), .sw_wval(status_wdata.ovf),
    .flag(f0_ovf));
  qct_sticky_flag u_f1_gfa (.clk(clk), .rst(rst), .set_evt(cap1),
    .sw_rd(ch1_status_rd), .sw_wr(ch1_status_wr), .sw_wval(status_wdata.gfa),
    .flag(f1_gfa));
  qct_sticky_flag u_f1_ovf (.clk(clk), .rst(rst), .set_evt(ovf1),
    .sw_rd(ch1_status_rd), .sw_wr(ch1_status_wr), .sw_wval(status_wdata.ovf),
    .flag(f1_ovf));
  qct_sticky_flag u_f1_unf (.clk(clk), .rst(rst), .set_evt(unf1),
    .sw_rd(ch1_status_rd), .sw_wr(ch1_status_wr), .sw_wval(status_wdata.unf),
    .flag(f1_unf));
  // Gather flags into one driver per status word; channel 0 counts up only
  assign st0 = '{gfa: f0_gfa, unf: 1'b0, ovf: f0_ovf};
  assign st1 = '{gfa: f1_gfa, unf: f1_unf, ovf: f1_ovf};

  ////////////////////////////////////////////////////////////////////////
  // Interrupt requests, registered so outputs come from flops
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq0_gfa_reg <= 1'b0;
      irq0_ovf_reg <= 1'b0;
      irq1_gfa_reg <= 1'b0;
      irq1_ovf_reg <= 1'b0;
      irq1_unf_reg <= 1'b0;
    end
    else
    begin
      // per-flag enables; capture reaches match-A request
      irq0_gfa_reg <= st0.gfa && ch0_irq_enable.gfa_en;
      irq0_ovf_reg <= st0.ovf && ch0_irq_enable.ovf_en;
      irq1_gfa_reg <= st1.gfa && ch1_irq_enable.gfa_en;
      irq1_ovf_reg <= st1.ovf && ch1_irq_enable.ovf_en;
      irq1_unf_reg <= st1.unf && ch1_irq_enable.unf_en;
    end
  end

  // Outputs
  assign ch0_counter = cnt0_reg;
  assign ch1_counter = cnt1_reg;
  assign ch0_general_reg_a = gra0_reg;
  assign ch1_general_reg_a = gra1_reg;
  assign ch0_status = st0;
  assign ch1_status = st1;
  assign ch0_match_a_irq = irq0_gfa_reg;
  assign ch0_ovf_irq = irq0_ovf_reg;
  assign ch1_match_a_irq = irq1_gfa_reg;
  assign ch1_ovf_irq = irq1_ovf_reg;
  assign ch1_unf_irq = irq1_unf_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  wire quiet1 = !ch1_cnt_wr && !clr1;

  phase_up_a: assert property (
    (up1 && phase_mode && quiet1) |=> (cnt1_reg == $past(cnt1_reg) + ONE))
    else $error("phase up did not increment");
  phase_down_a: assert property (
    (run1 && phase_mode && enc_ok && a_chg && (enc_phase_a_in ^ enc_phase_b_in) &&
     quiet1) |=> (cnt1_reg == $past(cnt1_reg) - ONE))
    else $error("phase down did not decrement");
  phase_noclk_a: assert property (
    (phase_mode && run1 && !a_chg && !b_chg && quiet1) |=> $stable(cnt1_reg))
    else $error("phase mode counted without encoder edge");
  ch1_capture_a: assert property (
    (ch1_io_control && ch0_match) |=> (gra1_reg == $past(cnt1_reg)) ##1 st1.gfa)
    else $error("ch1 capture on match missing");
  ch1_clear_a: assert property (
    (clr1 && !ch1_cnt_wr) |=> (cnt1_reg == '0))
    else $error("match did not clear ch1");
  preset_cnt_a: assert property (
    (active && ch1_cnt_wr) |=> (cnt1_reg == $past(sw_wdata)))
    else $error("ch1 preset lost");
  irq_enable_a: assert property (
    (st1.unf && ch1_irq_enable.unf_en) [*2] |-> ch1_unf_irq)
    else $error("enabled underflow did not request");
  irq_mask_a: assert property (
    !ch1_irq_enable.ovf_en |=> !ch1_ovf_irq)
    else $error("masked overflow requested");
  stop_hold_a: assert property (
    (!counter_start_reg[1] && !ch1_cnt_wr) |=> $stable(cnt1_reg))
    else $error("stopped ch1 counted");
  capture_edge_a: assert property (
    (ch0_cap && ch0_io_control == QCT_IO0_CAP_RISE) |-> pin_rise ##1
    (gra0_reg == $past(cnt0_reg)))
    else $error("rising capture wrong");
  capture_clear_a: assert property (
    (ch0_cap && clr0 && !ch0_cnt_wr) |=> (cnt0_reg == '0))
    else $error("capture did not clear ch0");
  capture_irq_a: assert property (
    (ch0_cap && ch0_irq_enable.gfa_en) |-> ##2 ch0_match_a_irq)
    else $error("capture request late");
  unit_stop_a: assert property (
    module_stop_control |=> ($stable(cnt0_reg) && $stable(cnt1_reg) && $stable(gra0_reg)))
    else $error("unit moved while stopped");
  wrap_flags_a: assert property (
    (unf1 || ovf1) |=> (st1.unf || st1.ovf))
    else $error("wrap flag missing");

  cov_phase_up_c: cover property (up1 && phase_mode);
  cov_phase_dn_c: cover property (dn1);
  cov_cap_clear_c: cover property (ch0_cap && clr0);
  cov_match_c: cover property (cap1 && clr1);

endmodule : qct_timer
`default_nettype wire

/* dv/qct_enc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module qct_enc_model (
  // Clock
  input wire logic clk,
  // Pins toward the timer
  output var logic enc_phase_a_in,
  output var logic enc_phase_b_in,
  output var logic ch0_pin_a
);
  logic [1:0] idx_reg;

  // Pins idle low; the timer sees no edge at reset release
  initial
  begin
    idx_reg = 2'h0;
    enc_phase_a_in = 1'b0;
    enc_phase_b_in = 1'b0;
    ch0_pin_a = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase order
  // Gray sequence so only one pin moves per step; gap gives slow encoders
  // An up step puts B ahead of A, which the timer counts upward
  task automatic step(input logic up, input int gap);
    begin
      @(negedge clk);
      idx_reg = up ? idx_reg + 2'h1 : idx_reg - 2'h1;
      enc_phase_a_in = idx_reg[1];
      enc_phase_b_in = idx_reg[1] ^ idx_reg[0];
      repeat (gap) @(negedge clk);
    end
  endtask : step

  // One high pulse of the measured pin, width in clock cycles
  task automatic pulse(input int width);
    begin
      @(negedge clk);
      ch0_pin_a = 1'b1;
      repeat (width) @(negedge clk);
      ch0_pin_a = 1'b0;
    end
  endtask : pulse
endmodule : qct_enc_model
`default_nettype wire

/* dv/qct_timer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module qct_timer_tb
  import qct_pkg::*;
;
  typedef struct packed {
    logic [4:0] irqs;
    logic [1:0] sel;
    logic [15:0] val;
  } qct_note_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stop_unit = 1'b0;
  logic [1:0] run = 2'h0;
  qct_ctrl_t ctrl0 = QCT_CTRL_RST;
  qct_ctrl_t ctrl1 = QCT_CTRL_RST;
  qct_io0_t io0 = QCT_IO0_COMPARE;
  logic io1 = 1'b0;
  qct_mode_t mode1 = QCT_MODE_PHASE1;
  qct_irq_en_t ien0 = 3'h0;
  qct_irq_en_t ien1 = 3'h0;
  logic [2:0] wr_strb = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic [1:0] st_rd = 2'h0;
  logic [1:0] st_wr = 2'h0;
  qct_status_t st_wdata = 3'h0;
  wire logic enc_a, enc_b, pin0;
  logic [15:0] cnt0, cnt1, gra0, gra1;
  qct_status_t sts0, sts1;
  logic irq0a, irq0v, irq1a, irq1v, irq1u;
  logic [4:0] irq_prev = 5'h00;
  wire logic [4:0] irq_vec = {irq0a, irq0v, irq1a, irq1v, irq1u};
  qct_note_t notes[$];
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 32'h7c9217c2;

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  qct_timer u_qct_timer (.clk(clk), .rst(rst), .module_stop_control(stop_unit),
    .counter_start_reg(run), .ch0_control_reg(ctrl0), .ch1_control_reg(ctrl1),
    .ch0_io_control(io0), .ch1_io_control(io1), .ch1_mode_reg(mode1),
    .ch0_irq_enable(ien0), .ch1_irq_enable(ien1), .ch0_cnt_wr(wr_strb[0]),
    .ch1_cnt_wr(wr_strb[1]), .ch0_gra_wr(wr_strb[2]), .sw_wdata(wdata),
    .ch0_status_rd(st_rd[0]), .ch1_status_rd(st_rd[1]), .ch0_status_wr(st_wr[0]),
    .ch1_status_wr(st_wr[1]), .status_wdata(st_wdata), .enc_phase_a_in(enc_a),
    .enc_phase_b_in(enc_b), .ch0_pin_a(pin0), .ch0_counter(cnt0), .ch1_counter(cnt1),
    .ch0_general_reg_a(gra0), .ch1_general_reg_a(gra1), .ch0_status(sts0),
    .ch1_status(sts1), .ch0_match_a_irq(irq0a), .ch0_ovf_irq(irq0v),
    .ch1_match_a_irq(irq1a), .ch1_ovf_irq(irq1v), .ch1_unf_irq(irq1u));

  qct_enc_model u_qct_enc_model (.clk(clk), .enc_phase_a_in(enc_a),
    .enc_phase_b_in(enc_b), .ch0_pin_a(pin0));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    begin
      check_count++;
      if (got !== exp)
      begin
        num_errors++;
        $display("ERROR %s expected %h seen %h", what, exp, got);
      end
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Strobe index: 0 ch0 counter, 1 ch1 counter, 2 ch0 general register A
  task automatic sw_write(input int which, input logic [15:0] v);
    begin
      @(negedge clk);
      wr_strb[which] = 1'b1;
      wdata = v;
      @(negedge clk);
      wr_strb = 3'h0;
    end
  endtask : sw_write

  // Optional status read, then a status write of v
  task automatic sw_flag(input int ch, input logic rd, input logic [2:0] v);
    begin
      @(negedge clk);
      st_rd[ch] = rd;
      @(negedge clk);
      st_rd = 2'h0;
      st_wr[ch] = 1'b1;
      st_wdata = v;
      @(negedge clk);
      st_wr = 2'h0;
    end
  endtask : sw_flag

  // Note an expected interrupt rise; sel 0 ch0 GRA, 1 ch1 GRA, 2 ch1 count, 3 none
  task automatic push(input logic [4:0] irqs, input logic [1:0] sel, input logic [15:0] v);
    notes.push_back(qct_note_t'{irqs: irqs, sel: sel, val: v});
  endtask : push

  task automatic test_end(input string name);
    $display("test %s done", name);
  endtask : test_end

  task automatic complete_run();
    begin
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: each interrupt rise consumes the oldest note
  always @(negedge clk)
  begin
    qct_note_t n;
    irq_prev <= irq_vec;
    if (!rst && (irq_vec & ~irq_prev) != 5'h00)
    begin
      n = (notes.size() != 0) ? notes.pop_front() : '0;
      check("irq rise", {11'h000, n.irqs}, {11'h000, irq_vec & ~irq_prev});
      if (n.sel != 2'h3)
        check("event value", n.val, n.sel == 2'h0 ? gra0 : n.sel == 2'h1 ? gra1 : cnt1);
    end
  end

  // Hang guard; the run needs well under this many cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      num_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    int n, m, w;
    logic [15:0] exp1, got;
    idle(6);
    rst = 1'b0;
    idle(1);
    check("reset gra0", 16'hffff, gra0);
    check("reset cnt1", 16'h0000, cnt1);
    check("reset status", 16'h0000, {10'h000, sts0, sts1});
    test_end("reset");
    // Encoder counting around a midscale preset
    run = 2'h2;
    sw_write(1, QCT_MIDSCALE);
    check("preset", 16'h8000, cnt1);
    n = 4 + ($random(seed) & 15);
    m = 1 + ($random(seed) & 3);
    for (int i = 0; i < n; i++) u_qct_enc_model.step(1'b1, i % 3);
    for (int i = 0; i < m; i++) u_qct_enc_model.step(1'b0, 0);
    exp1 = 16'h8000 + 16'(n - m);
    idle(3);
    check("phase count", exp1, cnt1);
    // Stopped unit, then stopped channel: a full cycle must not count
    for (int k = 0; k < 2; k++)
    begin
      stop_unit = (k == 0);
      run = (k == 0) ? 2'h2 : 2'h0;
      for (int i = 0; i < 4; i++) u_qct_enc_model.step(1'b1, 0);
      idle(3);
      check("held count", exp1, cnt1);
    end
    stop_unit = 1'b0;
    run = 2'h2;
    test_end("encoder");
    // Overflow, sticky flag, masked underflow
    ien1 = 3'h1;
    sw_write(1, 16'hffff);
    push(5'h02, 2'h2, 16'h0000);
    u_qct_enc_model.step(1'b1, 3);
    sw_flag(1, 1'b0, 3'h0);
    check("ovf kept", 16'h0001, {13'h0000, sts1});
    sw_flag(1, 1'b1, 3'h0);
    idle(2);
    check("ovf cleared", 16'h0000, {12'h000, irq1v, sts1});
    sw_write(1, 16'h0000);
    u_qct_enc_model.step(1'b0, 3);
    check("unf masked", 16'h0002, {12'h000, irq1u, sts1});
    push(5'h01, 2'h2, 16'hffff);
    ien1 = 3'h2;
    idle(3);
    sw_flag(1, 1'b1, 3'h0);
    test_end("wrap");
    // Channel 0 match captures and clears channel 1
    sw_write(1, QCT_MIDSCALE);
    n = 1 + ($random(seed) & 7);
    for (int i = 0; i < n; i++) u_qct_enc_model.step(1'b1, 1);
    ctrl0 = '{clk_sel: QCT_CLK_DIV1, clr_sel: QCT_CLR_CH0_GRA};
    ctrl1 = ctrl0;
    io1 = 1'b1;
    ien1 = 3'h4;
    sw_write(2, 16'h0028);
    sw_write(0, 16'h0000);
    push(5'h04, 2'h1, 16'h8000 + 16'(n));
    run = 2'h3;
    idle(45);
    run = 2'h0;
    check("ch1 cleared", 16'h0000, cnt1);
    sw_flag(1, 1'b1, 3'h0);
    // The match set the ch0 flag too; clear it so the capture rise is fresh
    sw_flag(0, 1'b1, 3'h0);
    test_end("match");
    // Pulse width: capture rise, then fall, counter cleared at each capture
    io0 = QCT_IO0_CAP_RISE;
    ien0 = 3'h4;
    run = 2'h1;
    w = 20 + ($random(seed) & 31);
    push(5'h10, 2'h3, 16'h0000);
    push(5'h10, 2'h0, 16'(w - 1));
    fork
      u_qct_enc_model.pulse(w);
      begin
        for (int i = 0; i < 10 && irq0a !== 1'b1; i++) @(negedge clk);
        sw_flag(0, 1'b1, 3'h0);
        io0 = QCT_IO0_CAP_FALL;
      end
    join
    idle(4);
    check("capture flag", 16'h0004, {13'h0000, sts0});
    sw_flag(0, 1'b1, 3'h0);
    test_end("width");
    // Clock source: 128 system clocks at each division
    io0 = QCT_IO0_COMPARE;
    ien0 = 3'h0;
    // Ch0 matches here; keep ch1 capture and its request out of the way
    io1 = 1'b0;
    ien1 = 3'h0;
    for (int d = 0; d < 4; d++)
    begin
      ctrl0 = '{clk_sel: qct_clk_sel_t'(d), clr_sel: QCT_CLR_NONE};
      sw_write(0, 16'h0000);
      run = 2'h1;
      idle(128);
      run = 2'h0;
      got = cnt0;
      exp1 = 16'(128 >> (2 * d));
      check("divided count", 16'h0001, {15'h0000, got + 16'h0001 >= exp1 && got <= exp1});
    end
    test_end("divider");
    check("notes used", 16'h0000, 16'(notes.size()));
    complete_run();
  end
endmodule : qct_timer_tb
`default_nettype wire
